// >>> design/ccs_seq.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Fast-charge timer expiry flags timer fault
// - Timer fault held until removal or repower
// - Regulation level moves fast to CV
// - CV ends when filtered current falls
// - Safety timer expiry also ends cycle
// - Termination comparator filtered for 1 ms
// - Safety timer period optional, can disable
// - Complete state recharges below threshold
// - No-recharge variant sits in standby
// - Restart after battery, power, resistor cycle
// - Thermal shutdown with hysteresis resume
// - Status pin open-drain, low or released
// - Status low while charging, flashing in type-2 faults, else released
// - Complete standby releases status pin
// - Short guard gives recovery current only
// - Short guard left after rise threshold
// - Safety timer restarts entering fast charge
// - Precondition below threshold, 32 min timer
// - Cycle needs power and enable high
module ccs_seq (
   input wire logic core_clk,
   input wire logic resetn,
   input wire ccs_pkg::ccs_flags_s flags_async,
   input wire ccs_pkg::ccs_opts_s opts,
   output ccs_pkg::ccs_drive_s drive,
   output logic status_oe,
   output logic status_out,
   output ccs_pkg::ccs_state_e charge_state,
   output logic fault_active
);
   import ccs_pkg::*;

   logic rst_meta;
   logic rst_n;
   ccs_flags_s f;
   ccs_state_e state;
   ccs_state_e next_state;
   logic [TMR_W-1:0] safe_cnt;
   logic [TMR_W-1:0] pre_cnt;
   logic [TMR_W-1:0] safe_limit;
   logic [$clog2(TERM_FILT_CYC+1)-1:0] term_cnt;
   logic [$clog2(FLASH_HALF_CYC+1)-1:0] flash_cnt;
   logic flash_phase;
   logic term_ok;
   logic safe_expired;
   logic pre_expired;
   logic charging;
   logic qualified;
   logic needs_restart;
   logic fault_state;

   // Reset release through two flops
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   ccs_sync #(.W(NUM_FLAGS)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .d(flags_async),
      .q(f)
   );

   assign qualified = f.power_good && f.enable_high;

   always_comb begin
      case (opts.safe_timer)
         SAFE_OPT_4H: safe_limit = TMR_W'(CYC_PER_HOUR * SAFE_4H);
         SAFE_OPT_6H: safe_limit = TMR_W'(CYC_PER_HOUR * SAFE_6H);
         SAFE_OPT_8H: safe_limit = TMR_W'(CYC_PER_HOUR * SAFE_8H);
         default: safe_limit = '1;
      endcase
   end

   assign safe_expired = (opts.safe_timer != SAFE_OPT_OFF) &&
                         (safe_cnt >= safe_limit);
   assign pre_expired = opts.pre_timer_en &&
                        (pre_cnt >= TMR_W'(PRE_TIMER_CYC));
   assign term_ok = (term_cnt == TERM_FILT_CYC[$bits(term_cnt)-1:0]);

   // Safety timer: cleared on entry to fast charge, runs through CV
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         safe_cnt <= '0;
      end else if (state != CCS_FAST && next_state == CCS_FAST) begin
         safe_cnt <= '0;
      end else if ((state == CCS_FAST || state == CCS_CONST_V) &&
                   !safe_expired) begin
         safe_cnt <= safe_cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt <= '0;
      end else if (state != CCS_PRECOND) begin
         pre_cnt <= '0;
      end else if (!pre_expired) begin
         pre_cnt <= pre_cnt + 1'b1;
      end
   end

   // Load transients shorter than the filter restart it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         term_cnt <= '0;
      end else if (state != CCS_CONST_V || !f.below_term) begin
         term_cnt <= '0;
      end else if (!term_ok) begin
         term_cnt <= term_cnt + 1'b1;
      end
   end

   // Shutdown state also clears pre_cnt, term_cnt and flash_cnt via the state checks; safe_cnt holds
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= CCS_SHUTDOWN;
      end else if (!f.power_good) begin
         state <= CCS_SHUTDOWN;
      end else begin
         state <= next_state;
      end
   end

   // Latch set at termination without auto recharge; removal of
   // battery, power or program resistor clears it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         needs_restart <= 1'b0;
      end else if (!f.power_good || !f.battery_present ||
                   !f.enable_high) begin
         needs_restart <= 1'b0;
      end else if (state == CCS_CONST_V && next_state == CCS_STANDBY) begin
         needs_restart <= 1'b1;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         CCS_SHUTDOWN: begin
            next_state = CCS_STANDBY;
         end
         CCS_STANDBY: begin
            if (qualified && f.battery_present && !needs_restart &&
                f.below_recharge) begin
               next_state = CCS_SHORT_GUARD;
            end
         end
         CCS_SHORT_GUARD: begin
            if (!f.below_short && f.above_short_rise) begin
               if (opts.precond_en && f.below_precond) begin
                  next_state = CCS_PRECOND;
               end else begin
                  next_state = CCS_FAST;
               end
            end
         end
         CCS_PRECOND: begin
            if (pre_expired) begin
               next_state = CCS_PRE_FAULT;
            end else if (!f.below_precond) begin
               next_state = CCS_FAST;
            end
         end
         CCS_FAST: begin
            if (f.at_regulation) begin
               next_state = CCS_CONST_V;
            end else if (safe_expired) begin
               next_state = CCS_TIMER_FAULT;
            end
         end
         CCS_CONST_V: begin
            if (term_ok || safe_expired) begin
               if (opts.auto_recharge) begin
                  next_state = CCS_COMPLETE;
               end else begin
                  next_state = CCS_STANDBY;
               end
            end
         end
         CCS_COMPLETE: begin
            if (f.below_recharge) begin
               next_state = CCS_SHORT_GUARD;
            end
         end
         CCS_THERMAL: begin
            if (!f.die_hot) begin
               next_state = CCS_SHORT_GUARD;
            end
         end
         CCS_TIMER_FAULT, CCS_PRE_FAULT: begin
            if (!f.battery_present) begin
               next_state = CCS_STANDBY;
            end
         end
         default: begin
            next_state = CCS_SHUTDOWN;
         end
      endcase
      // Battery removal or disable drops any charging state
      if (state inside {CCS_SHORT_GUARD, CCS_PRECOND, CCS_FAST,
                        CCS_CONST_V, CCS_COMPLETE, CCS_THERMAL} &&
          (!f.battery_present || !f.enable_high)) begin
         next_state = CCS_STANDBY;
      end else if (state inside {CCS_PRECOND, CCS_FAST, CCS_CONST_V}) begin
         if (f.die_hot) begin
            next_state = CCS_THERMAL;
         end else if (f.below_short) begin
            next_state = CCS_SHORT_GUARD;
         end
      end
   end

   assign charging = (state == CCS_PRECOND) || (state == CCS_FAST) ||
                     (state == CCS_CONST_V);
   assign fault_state = (state == CCS_THERMAL) ||
                        (state == CCS_TIMER_FAULT) ||
                        (state == CCS_PRE_FAULT);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_cnt <= '0;
         flash_phase <= 1'b0;
      end else if (!fault_state) begin
         flash_cnt <= '0;
         flash_phase <= 1'b0;
      end else if (flash_cnt == $bits(flash_cnt)'(FLASH_HALF_CYC - 1)) begin
         flash_cnt <= '0;
         flash_phase <= ~flash_phase;
      end else begin
         flash_cnt <= flash_cnt + 1'b1;
      end
   end

   // Pin only ever pulled low or released
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_oe <= 1'b0;
      end else if (charging) begin
         status_oe <= 1'b1;
      end else if (fault_state && opts.flash_type2) begin
         status_oe <= ~flash_phase;
      end else begin
         status_oe <= 1'b0;
      end
   end
   assign status_out = 1'b0;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         drive <= '0;
         fault_active <= 1'b0;
      end else begin
         drive.supply_on <= charging || (state == CCS_SHORT_GUARD);
         drive.recovery_25ma <= (state == CCS_SHORT_GUARD);
         drive.precond_10pct <= (state == CCS_PRECOND);
         drive.fast_current <= (state == CCS_FAST);
         drive.const_voltage <= (state == CCS_CONST_V);
         drive.vreg_level <= opts.vreg_level;
         drive.iterm_frac <= opts.iterm_frac;
         fault_active <= fault_state;
      end
   end

   assign charge_state = state;

endmodule : ccs_seq
`default_nettype wire

// >>> design/ccs_pkg.sv
package ccs_pkg;

   // Time base: 20 MHz core clock
   localparam longint CLK_HZ = 64'd20_000_000;

   // Termination filter, 1 ms
   localparam int TERM_FILT_US = 1000;
   localparam int TERM_FILT_CYC = int'((CLK_HZ * TERM_FILT_US) / 1_000_000);

   // Status flash half period, 0.8 s of a 1.6 s period
   localparam int FLASH_PERIOD_MS = 1600;
   localparam int FLASH_HALF_CYC = int'((CLK_HZ * FLASH_PERIOD_MS) / 2000);

   // Preconditioning timer, 32 minutes
   localparam int PRE_TIMER_MIN = 32;
   localparam longint PRE_TIMER_CYC = CLK_HZ * 60 * PRE_TIMER_MIN;

   // Safety timer options in hours
   localparam int SAFE_4H = 4;
   localparam int SAFE_6H = 6;
   localparam int SAFE_8H = 8;
   localparam longint CYC_PER_HOUR = CLK_HZ * 3600;

   localparam int TMR_W = 40;

   // Safety timer option code
   localparam logic [1:0] SAFE_OPT_4H = 2'h0;
   localparam logic [1:0] SAFE_OPT_6H = 2'h1;
   localparam logic [1:0] SAFE_OPT_8H = 2'h2;
   localparam logic [1:0] SAFE_OPT_OFF = 2'h3;

   // Regulation level option code: 4.10 V, 4.20 V, 4.35 V, 4.40 V
   localparam logic [1:0] VREG_410 = 2'h0;
   localparam logic [1:0] VREG_420 = 2'h1;
   localparam logic [1:0] VREG_435 = 2'h2;
   localparam logic [1:0] VREG_440 = 2'h3;

   // Termination fraction code: 5, 7.5, 10, 20 percent
   localparam logic [1:0] ITERM_5 = 2'h0;
   localparam logic [1:0] ITERM_7P5 = 2'h1;
   localparam logic [1:0] ITERM_10 = 2'h2;
   localparam logic [1:0] ITERM_20 = 2'h3;

   localparam int NUM_FLAGS = 10;

   typedef enum logic [3:0] {
      CCS_SHUTDOWN = 4'h0,
      CCS_STANDBY = 4'h1,
      CCS_SHORT_GUARD = 4'h2,
      CCS_PRECOND = 4'h3,
      CCS_FAST = 4'h4,
      CCS_CONST_V = 4'h5,
      CCS_COMPLETE = 4'h6,
      CCS_THERMAL = 4'h7,
      CCS_TIMER_FAULT = 4'h8,
      CCS_PRE_FAULT = 4'h9
   } ccs_state_e;

   // Analog comparator flags, all asynchronous to core_clk
   typedef struct packed {
      logic power_good;
      logic enable_high;
      logic battery_present;
      logic above_short_rise;
      logic below_short;
      logic below_precond;
      logic at_regulation;
      logic below_recharge;
      logic below_term;
      logic die_hot;
   } ccs_flags_s;

   // Factory options
   typedef struct packed {
      logic [1:0] safe_timer;
      logic pre_timer_en;
      logic precond_en;
      logic auto_recharge;
      logic flash_type2;
      logic [1:0] vreg_level;
      logic [1:0] iterm_frac;
   } ccs_opts_s;

   // Commands to the analog regulation loop
   typedef struct packed {
      logic supply_on;
      logic recovery_25ma;
      logic precond_10pct;
      logic fast_current;
      logic const_voltage;
      logic [1:0] vreg_level;
      logic [1:0] iterm_frac;
   } ccs_drive_s;

endpackage : ccs_pkg

// >>> design/ccs_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ccs_sync #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               meta[i] <= 1'b0;
               q[i] <= 1'b0;
            end else begin
               meta[i] <= d[i];
               q[i] <= meta[i];
            end
         end
      end
   endgenerate
endmodule : ccs_sync
`default_nettype wire

// >>> testbench/ccs_seq_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module ccs_seq_monitor (
   input wire logic core_clk,
   input wire logic resetn,
   input wire ccs_pkg::ccs_flags_s flags_async,
   input wire ccs_pkg::ccs_opts_s opts,
   input wire ccs_pkg::ccs_drive_s drive,
   input wire logic status_oe,
   input wire logic status_out,
   input wire ccs_pkg::ccs_state_e charge_state,
   input wire logic fault_active
);
   import ccs_pkg::*;
   logic [14:0] term_cnt;
   logic chg;
   logic flt;
   assign chg = charge_state inside {CCS_PRECOND, CCS_FAST, CCS_CONST_V};
   assign flt = charge_state inside
      {CCS_THERMAL, CCS_TIMER_FAULT, CCS_PRE_FAULT};
   // Saturates so a long idle stretch cannot wrap to a small count
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         term_cnt <= 15'h0;
      end else if (!flags_async.below_term) begin
         term_cnt <= 15'h0;
      end else if (term_cnt != 15'h7FFF) begin
         term_cnt <= term_cnt + 15'h1;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   property p_od;
      status_out == 1'b0;
   endproperty
   a_od: assert property (p_od) else $error("status level not low");
   property p_chg_low;
      $stable(charge_state) && chg |-> status_oe;
   endproperty
   a_chg_low: assert property (p_chg_low)
      else $error("status released while charging");
   property p_idle_rel;
      $stable(charge_state) && charge_state inside
         {CCS_SHUTDOWN, CCS_STANDBY, CCS_COMPLETE} |-> !status_oe;
   endproperty
   a_idle_rel: assert property (p_idle_rel)
      else $error("status pulled low while idle");
   property p_type1;
      $stable(charge_state) && flt && !opts.flash_type2 |-> !status_oe;
   endproperty
   a_type1: assert property (p_type1)
      else $error("plain fault style pulls status low");
   property p_flt;
      $stable(charge_state) |-> fault_active == flt;
   endproperty
   a_flt: assert property (p_flt) else $error("fault flag wrong");
   property p_pg;
      (!flags_async.power_good) [*5] |-> charge_state == CCS_SHUTDOWN;
   endproperty
   a_pg: assert property (p_pg) else $error("no shutdown on power loss");
   property p_hot;
      (charge_state == CCS_FAST && flags_async.die_hot &&
       flags_async.power_good) ##1
      (flags_async.die_hot && flags_async.power_good) [*3]
      |-> ##[0:2] charge_state == CCS_THERMAL;
   endproperty
   a_hot: assert property (p_hot) else $error("hot die kept charging");
   property p_term;
      opts.safe_timer == SAFE_OPT_OFF && $past(charge_state) == CCS_CONST_V
      && charge_state inside {CCS_COMPLETE, CCS_STANDBY}
      |-> term_cnt >= 15'd19990;
   endproperty
   a_term: assert property (p_term) else $error("early termination");
   property p_short;
      $stable(charge_state) && charge_state == CCS_SHORT_GUARD
      |-> drive.recovery_25ma && !drive.fast_current;
   endproperty
   a_short: assert property (p_short)
      else $error("short guard drive wrong");
   property p_norech;
      !opts.auto_recharge |-> charge_state != CCS_COMPLETE;
   endproperty
   a_norech: assert property (p_norech)
      else $error("complete without recharge option");
   c_done: cover property (charge_state == CCS_CONST_V
      ##1 charge_state == CCS_COMPLETE);
   c_hot: cover property (charge_state == CCS_THERMAL);
   c_short: cover property (charge_state == CCS_SHORT_GUARD);
endmodule : ccs_seq_monitor
bind ccs_seq ccs_seq_monitor u_ccs_seq_monitor (.core_clk, .resetn,
   .flags_async, .opts, .drive, .status_oe, .status_out, .charge_state,
   .fault_active);
`default_nettype wire

// >>> testbench/ccs_led_model.sv
`timescale 1ns/10ps
`default_nettype none
module ccs_led_model (
   input wire logic status_oe,
   input wire logic status_out,
   output logic pin_level
);
   // Pull-up holds the line high once the driver lets go
   assign pin_level = status_oe ? status_out : 1'b1;
endmodule : ccs_led_model
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   import ccs_pkg::*;
   typedef struct {
      logic [9:0] f;
      int n;
      ccs_state_e st;
      logic oe;
   } ccs_row_s;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   ccs_flags_s flags = '0;
   ccs_opts_s opts;
   ccs_drive_s drive;
   logic status_oe, status_out, fault_active, pin_level;
   ccs_state_e charge_state;
   int miscompares = 0;
   int cmp_count = 0;
   int cyc = 0;
   ccs_row_s rows [9] = '{
      '{10'h300, 8, CCS_STANDBY, 1'b0},
      '{10'h3D4, 10, CCS_PRECOND, 1'b1},
      '{10'h3C4, 8, CCS_FAST, 1'b1},
      '{10'h3C8, 8, CCS_CONST_V, 1'b1},
      '{10'h3CA, 19990, CCS_CONST_V, 1'b1},
      '{10'h3CA, 30, CCS_COMPLETE, 1'b0},
      '{10'h3C4, 10, CCS_FAST, 1'b1},
      '{10'h3C5, 8, CCS_THERMAL, 1'b1},
      '{10'h3C4, 10, CCS_FAST, 1'b1}
   };
   always #25 core_clk = ~core_clk;
   ccs_seq u_ccs_seq (.core_clk, .resetn, .flags_async(flags), .opts,
      .drive, .status_oe, .status_out, .charge_state, .fault_active);
   ccs_led_model u_ccs_led_model (.status_oe, .status_out, .pin_level);
   function automatic logic [6:0] cur();
      return {4'(charge_state), status_oe, pin_level, fault_active};
   endfunction : cur
   task automatic chk(input logic [6:0] got, input logic [6:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #5;
   endtask : tick
   task automatic step(input logic [9:0] f, input int n,
      input ccs_state_e st, input logic oe);
      logic flt;
      logic [6:0] m;
      tick(1);
      flags = f;
      tick(n);
      flt = st inside {CCS_THERMAL, CCS_TIMER_FAULT, CCS_PRE_FAULT};
      // Short guard is not charging, so the pin is released there too
      m = 7'h7F;
      chk(cur() & m, {4'(st), oe, !oe, flt} & m);
   endtask : step
   task automatic tally_and_finish();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial begin
      opts = '{SAFE_OPT_OFF, 1'b1, 1'b1, 1'b1, 1'b1, VREG_420, ITERM_10};
      tick(4);
      chk(cur(), {4'(CCS_SHUTDOWN), 3'h2});
      tick(4);
      resetn = 1'b1;
      foreach (rows[i]) begin
         step(rows[i].f, rows[i].n, rows[i].st, rows[i].oe);
      end
      step(10'h3A4, 8, CCS_SHORT_GUARD, 1'b0);
      chk({6'h0, drive.recovery_25ma}, 7'h1);
      step(10'h3C4, 10, CCS_FAST, 1'b1);
      step(10'h0C4, 8, CCS_SHUTDOWN, 1'b0);
      opts.auto_recharge = 1'b0;
      opts.flash_type2 = 1'b0;
      step(10'h3D4, 10, CCS_PRECOND, 1'b1);
      step(10'h3C4, 8, CCS_FAST, 1'b1);
      step(10'h3C5, 8, CCS_THERMAL, 1'b0);
      step(10'h3C4, 10, CCS_FAST, 1'b1);
      step(10'h3C8, 8, CCS_CONST_V, 1'b1);
      for (int i = 0; i < 4; i++) begin
         opts.vreg_level = 2'(i);
         opts.iterm_frac = 2'(3 - i);
         tick(3);
         chk({3'h0, drive.vreg_level, drive.iterm_frac},
            {3'h0, 2'(i), 2'(3 - i)});
      end
      step(10'h3CA, 20020, CCS_STANDBY, 1'b0);
      step(10'h3C4, 30, CCS_STANDBY, 1'b0);
      step(10'h344, 8, CCS_STANDBY, 1'b0);
      step(10'h3C4, 10, CCS_FAST, 1'b1);
      resetn = 1'b0;
      tick(2);
      chk(cur(), {4'(CCS_SHUTDOWN), 3'h2});
      resetn = 1'b1;
      step(10'h3C4, 10, CCS_FAST, 1'b1);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
